// *** logic/psc_sync.v ***
`timescale 1ns/1ps
// three-stage synchroniser, output moves only when stages two and three agree
module psc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // psc_sync

// *** logic/psc_top.v ***
`timescale 1ns/1ps
`include "psc_defines.vh"
// Functional notes
// - cpu is always in exactly one of five states; power-down has three modes
// - every exception fetches a start vector and branches there
// - interrupt and trap push pc then ccr via stack pointer first
// - priority: reset over interrupt over trap
// - interrupts sampled at instruction or exception-sequence end, and throughout sleep and software standby
// - no sampling after ccr and/or/xor/load ops or right after reset
// - trap accepted any time in execution, handled when executed
// - reset pin low stops everything and enters reset state
// - reset exception starts clock-synchronously when reset pin rises
// - reset sets global mask flag; all interrupts masked in reset
// - all interrupts, nmi too, blocked during and right after reset sequence
// - exception sets mask flag, also user flag for interrupt and trap when user enable is 0
// - foreign bus request releases bus; cpu halts meanwhile
// - no interrupt accepted while bus released
// - watchdog overflow also enters reset state
// - sleep with standby select 0 enters sleep, registers kept
// - sleep with standby select 1 halts clock and resets modules
// - hardware standby pin low halts clock and resets modules
// - reset state holds cpu and modules initialised and halted
// - user enable 0 makes user flag a mask, 1 a plain bit
module psc_top #(
  parameter HW_STANDBY_IN_N_WAIT = `PSC_HW_STANDBY_IN_N_WAIT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reset_in_n,
  input wire hw_standby_in_n,
  input wire bus_req,
  input wire nmi_req,
  input wire irq_req,
  input wire irq_pri_req,
  input wire [7:0] irq_vec,
  input wire wdt_overflow,
  input wire insn_done,
  input wire insn_ccr_op,
  input wire insn_sleep,
  input wire insn_trap,
  input wire [1:0] trap_num,
  output reg [2:0] cpu_state,
  output reg [1:0] pd_mode,
  output reg cpu_halt,
  output reg clock_halt,
  output reg module_reset,
  output reg bus_grant,
  output reg stack_push,
  output reg push_ccr,
  output reg [23:0] stack_addr,
  output reg vec_fetch,
  output reg [7:0] vec_num,
  output reg branch
);
  // ----------------------------------------
  // states and codes
  // ----------------------------------------
  localparam [2:0] ST_EXEC = 3'h0;
  localparam [2:0] ST_EXC = 3'h1;
  localparam [2:0] ST_PDOWN = 3'h2;
  localparam [2:0] ST_RESET = 3'h3;
  localparam [2:0] ST_BUSREL = 3'h4;
  localparam [1:0] PD_SLEEP = 2'h0;
  localparam [1:0] PD_SWSTBY = 2'h1;
  localparam [1:0] PD_HWSTBY = 2'h2;
  localparam [1:0] EX_RESET = 2'h0;
  localparam [1:0] EX_IRQ = 2'h1;
  localparam [1:0] EX_TRAP = 2'h2;
  localparam [2:0] STEP_PC = 3'h0;
  localparam [2:0] STEP_CCR = 3'h1;
  localparam [2:0] STEP_MASK = 3'h2;
  localparam [2:0] STEP_VEC = 3'h3;
  localparam [2:0] STEP_BR = 3'h4;
  localparam WW = 18;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [5:0] pins_s;
  psc_sync #(.W(6), .RST_VAL(6'h03)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({irq_pri_req, irq_req, nmi_req, bus_req, hw_standby_in_n, reset_in_n}),
    .sync_out(pins_s)
  );
  wire rst_pin_n = pins_s[0];
  wire hwstby_n = pins_s[1];
  wire busreq_s = pins_s[2];
  wire nmi_s = pins_s[3];
  wire irq_s = pins_s[4];
  wire irqpri_s = pins_s[5];

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  reg [7:0] sysctrl_q;
  reg ccr_i_q;
  reg ccr_ui_q;
  reg [23:0] sp_q;
  reg [1:0] ex_type_q;
  reg [2:0] step_q;
  reg [7:0] vec_q;
  reg irq_block_q;
  reg hw_standby_in_n_load_q;

  wire sw_standby_select = sysctrl_q[`PSC_SYS_SW_STANDBY_SELECT_BIT];
  wire ue = sysctrl_q[`PSC_SYS_UE_BIT];

  // user flag masks only when user enable is clear
  wire ui_masks = ~ue & ccr_ui_q;
  wire irq_acc = ~ccr_i_q & (irq_s | irqpri_s) | (ccr_i_q & ~ui_masks & ~ue & irqpri_s);
  wire any_irq = ~irq_block_q & (nmi_s | irq_acc);
  wire [7:0] irq_vnum = nmi_s ? `PSC_VEC_NMI : irq_vec;
  wire rst_req = ~rst_pin_n | wdt_overflow;

  wire hw_standby_in_n_busy;
  wire hw_standby_in_n_done;
  psc_wait_cnt #(.W(WW)) u_wait (
    .pclk(pclk),
    .presetn(presetn),
    .load(hw_standby_in_n_load_q),
    .load_val(HW_STANDBY_IN_N_WAIT[WW-1:0]),
    .busy(hw_standby_in_n_busy),
    .done(hw_standby_in_n_done)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire apb_acc = psel & penable & ~pready;
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire hit = (paddr == `PSC_OFF_SYSCTRL) | (paddr == `PSC_OFF_CCR) |
             (paddr == `PSC_OFF_STATUS) | (paddr == `PSC_OFF_SP);
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (paddr)
      `PSC_OFF_SYSCTRL: rd_d = {24'h000000, sysctrl_q};
      `PSC_OFF_CCR: rd_d = {24'h000000, ccr_i_q, ccr_ui_q, 6'h00};
      `PSC_OFF_STATUS: rd_d = {24'h000000, ex_type_q, 1'b0, pd_mode, cpu_state};
      `PSC_OFF_SP: rd_d = {8'h00, sp_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~hit;
      if (apb_acc) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysctrl_q <= `PSC_SYSCTRL_RST;
    end else if (apb_wr && paddr == `PSC_OFF_SYSCTRL) begin
      sysctrl_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // processing state machine
  // ----------------------------------------
  // mask set by hardware beats a software ccr write in the same cycle
  wire hw_mask = (cpu_state == ST_RESET) | (cpu_state == ST_EXC && step_q == STEP_MASK);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_i_q <= 1'b1;
      ccr_ui_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == `PSC_OFF_CCR) begin
        ccr_i_q <= pwdata[`PSC_CCR_I_BIT];
        ccr_ui_q <= pwdata[`PSC_CCR_UI_BIT];
      end
      if (hw_mask) begin
        ccr_i_q <= 1'b1;
        if (cpu_state == ST_EXC && ex_type_q != EX_RESET && !ue) begin
          ccr_ui_q <= 1'b1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_state <= ST_RESET;
      pd_mode <= PD_SLEEP;
      ex_type_q <= EX_RESET;
      step_q <= STEP_VEC;
      vec_q <= `PSC_VEC_RESET;
      sp_q <= `PSC_SP_RST;
      irq_block_q <= 1'b1;
      hw_standby_in_n_load_q <= 1'b0;
      stack_push <= 1'b0;
      push_ccr <= 1'b0;
      stack_addr <= 24'h000000;
      vec_fetch <= 1'b0;
      vec_num <= 8'h00;
      branch <= 1'b0;
    end else begin
      stack_push <= 1'b0;
      vec_fetch <= 1'b0;
      branch <= 1'b0;
      hw_standby_in_n_load_q <= 1'b0;
      if (apb_wr && paddr == `PSC_OFF_SP) begin
        sp_q <= pwdata[23:0];
      end
      if (!hwstby_n) begin
        cpu_state <= ST_PDOWN;
        pd_mode <= PD_HWSTBY;
      end else if (rst_req) begin
        cpu_state <= ST_RESET;
        irq_block_q <= 1'b1;
      end else begin
        case (cpu_state)
          ST_RESET: begin
            // pin back high: reset sequence, vector only, no stacking
            cpu_state <= ST_EXC;
            ex_type_q <= EX_RESET;
            step_q <= STEP_MASK;
            vec_q <= `PSC_VEC_RESET;
          end
          ST_EXEC: begin
            if (insn_done) begin
              if (any_irq && !insn_ccr_op) begin
                cpu_state <= ST_EXC;
                ex_type_q <= EX_IRQ;
                step_q <= STEP_PC;
                vec_q <= irq_vnum;
              end else if (insn_trap) begin
                cpu_state <= ST_EXC;
                ex_type_q <= EX_TRAP;
                step_q <= STEP_PC;
                vec_q <= `PSC_VEC_TRAP_BASE + {6'h00, trap_num};
              end else if (insn_sleep) begin
                cpu_state <= ST_PDOWN;
                pd_mode <= sw_standby_select ? PD_SWSTBY : PD_SLEEP;
              end else if (busreq_s) begin
                cpu_state <= ST_BUSREL;
              end
              if (!insn_ccr_op) begin
                irq_block_q <= 1'b0;
              end
            end else if (busreq_s) begin
              cpu_state <= ST_BUSREL;
            end
          end
          ST_BUSREL: begin
            // interrupts simply not looked at here
            if (!busreq_s) begin
              cpu_state <= ST_EXEC;
            end
          end
          ST_EXC: begin
            case (step_q)
              STEP_PC: begin
                sp_q <= sp_q - `PSC_SP_STEP;
                stack_addr <= sp_q - `PSC_SP_STEP;
                stack_push <= 1'b1;
                push_ccr <= 1'b0;
                step_q <= STEP_CCR;
              end
              STEP_CCR: begin
                sp_q <= sp_q - `PSC_SP_STEP;
                stack_addr <= sp_q - `PSC_SP_STEP;
                stack_push <= 1'b1;
                push_ccr <= 1'b1;
                step_q <= STEP_MASK;
              end
              STEP_MASK: begin
                step_q <= STEP_VEC;
              end
              STEP_VEC: begin
                vec_fetch <= 1'b1;
                vec_num <= vec_q;
                step_q <= STEP_BR;
              end
              STEP_BR: begin
                branch <= 1'b1;
                if (ex_type_q == EX_RESET) begin
                  cpu_state <= ST_EXEC;
                  // no sampling here; the first instruction boundary may take one
                  irq_block_q <= 1'b0;
                end else if (any_irq) begin
                  // chained interrupt at end of exception sequence
                  ex_type_q <= EX_IRQ;
                  step_q <= STEP_PC;
                  vec_q <= irq_vnum;
                end else begin
                  cpu_state <= ST_EXEC;
                end
              end
              default: begin
                step_q <= STEP_VEC;
              end
            endcase
          end
          ST_PDOWN: begin
            case (pd_mode)
              PD_SLEEP: begin
                if (any_irq) begin
                  cpu_state <= ST_EXC;
                  ex_type_q <= EX_IRQ;
                  step_q <= STEP_PC;
                  vec_q <= irq_vnum;
                end
              end
              PD_SWSTBY: begin
                // oscillator settling wait before the wake exception
                if (any_irq && !hw_standby_in_n_busy && !hw_standby_in_n_load_q && !hw_standby_in_n_done) begin
                  hw_standby_in_n_load_q <= 1'b1;
                  vec_q <= irq_vnum;
                end
                if (hw_standby_in_n_done) begin
                  cpu_state <= ST_EXC;
                  ex_type_q <= EX_IRQ;
                  step_q <= STEP_PC;
                end
              end
              PD_HWSTBY: begin
                // leaving hardware standby always goes through reset
                cpu_state <= ST_RESET;
                irq_block_q <= 1'b1;
              end
              default: begin
                cpu_state <= ST_RESET;
              end
            endcase
          end
          default: begin
            cpu_state <= ST_RESET;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // halt, clock and module controls
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt <= 1'b1;
      clock_halt <= 1'b0;
      module_reset <= 1'b1;
      bus_grant <= 1'b0;
    end else begin
      cpu_halt <= (cpu_state == ST_RESET) | (cpu_state == ST_PDOWN) | (cpu_state == ST_BUSREL);
      clock_halt <= (cpu_state == ST_PDOWN) & (pd_mode != PD_SLEEP) & ~hw_standby_in_n_busy;
      module_reset <= (cpu_state == ST_RESET) | ((cpu_state == ST_PDOWN) & (pd_mode != PD_SLEEP));
      bus_grant <= (cpu_state == ST_BUSREL);
    end
  end
endmodule // psc_top

// *** logic/psc_wait_cnt.v ***
`timescale 1ns/1ps
// load-and-count-down timer, done pulses for one cycle when the count reaches zero
module psc_wait_cnt #(
  parameter W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [W-1:0] load_val,
  output reg busy,
  output reg done
);
  reg [W-1:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule // psc_wait_cnt

// *** shared/psc_defines.vh ***
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PSC_OFF_SYSCTRL 8'h00
`define PSC_OFF_CCR 8'h04
`define PSC_OFF_STATUS 8'h08
`define PSC_OFF_SP 8'h0C
// ----------------------------------------
// field positions
// ----------------------------------------
`define PSC_SYS_SW_STANDBY_SELECT_BIT 7
`define PSC_SYS_UE_BIT 3
`define PSC_CCR_I_BIT 7
`define PSC_CCR_UI_BIT 6
// ----------------------------------------
// reset values
// ----------------------------------------
`define PSC_SYSCTRL_RST 8'h0B
`define PSC_CCR_RST 8'h80
`define PSC_SP_RST 24'h000000
// ----------------------------------------
// vectors and timing
// ----------------------------------------
`define PSC_VEC_RESET 8'h00
`define PSC_VEC_NMI 8'h07
`define PSC_VEC_TRAP_BASE 8'h08
`define PSC_SP_STEP 24'h000004
`define PSC_HW_STANDBY_IN_N_WAIT 8192
`endif

// *** testbench/psc_bus_peer.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// foreign bus master
// ----------------------------------------
module psc_bus_peer (
  input wire pclk,
  input wire presetn,
  input wire go,
  input wire [3:0] hold_len,
  input wire bus_grant,
  output logic bus_req
);
  logic [3:0] cnt_q;
  // request held until granted, then kept for hold_len+1 granted cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_req <= 1'b0;
      cnt_q <= 4'h0;
    end else if (go && !bus_req) begin
      bus_req <= 1'b1;
      cnt_q <= hold_len;
    end else if (bus_req && bus_grant) begin
      if (cnt_q == 4'h0) bus_req <= 1'b0;
      else cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // psc_bus_peer

// *** testbench/psc_top_monitor.sv ***
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_monitor #(
  parameter HW_STANDBY_IN_N_WAIT = 8
) (
  input wire pclk,
  input wire presetn,
  input wire reset_in_n,
  input wire hw_standby_in_n,
  input wire wdt_overflow,
  input wire [2:0] cpu_state,
  input wire [1:0] pd_mode,
  input wire cpu_halt,
  input wire clock_halt,
  input wire module_reset,
  input wire bus_grant,
  input wire stack_push,
  input wire push_ccr,
  input wire [23:0] stack_addr,
  input wire vec_fetch,
  input wire branch
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_push_pc; stack_push && !push_ccr; endsequence
  sequence s_push_ccr; stack_push && push_ccr; endsequence
  a_state_legal: assert property (cpu_state <= 3'h4 && (cpu_state != 3'h2 || pd_mode <= 2'h2))
    else $error("illegal state or mode");
  a_push_order: assert property (s_push_pc |=> s_push_ccr ##2 vec_fetch)
    else $error("push order wrong");
  a_sp_step: assert property (s_push_pc ##1 s_push_ccr |-> stack_addr == $past(stack_addr) - `PSC_SP_STEP)
    else $error("stack step wrong");
  a_vec_branch: assert property (vec_fetch |=> branch)
    else $error("no branch after vector fetch");
  a_bus_quiet: assert property (cpu_state == 3'h4 |-> !stack_push && !vec_fetch)
    else $error("exception while bus released");
  a_grant_lag: assert property (1'b1 |=> bus_grant == ($past(cpu_state) == 3'h4))
    else $error("grant not tied to state");
  a_pin_reset: assert property ((!reset_in_n && hw_standby_in_n) [*6] |-> cpu_state == 3'h3)
    else $error("reset pin ignored");
  a_wdt_reset: assert property (wdt_overflow && hw_standby_in_n |-> ##[1:2] cpu_state == 3'h3)
    else $error("watchdog ignored");
  a_reset_init: assert property (cpu_state == 3'h3 |=> module_reset && cpu_halt)
    else $error("reset not halting");
  a_sleep_run: assert property (cpu_state == 3'h2 && pd_mode == 2'h0 |=> cpu_halt && !clock_halt)
    else $error("sleep halt wrong");
  // entry edge only: clock restarts during the oscillator wait
  a_hw_standby_in_n_halt: assert property (cpu_state == 3'h2 && $past(cpu_state) != 3'h2 && pd_mode != 2'h0
    |=> clock_halt && module_reset)
    else $error("standby not halting");
endmodule // psc_monitor
bind psc_top psc_monitor #(.HW_STANDBY_IN_N_WAIT(HW_STANDBY_IN_N_WAIT)) u_mon (.pclk, .presetn, .reset_in_n, .hw_standby_in_n,
  .wdt_overflow, .cpu_state, .pd_mode, .cpu_halt, .clock_halt, .module_reset, .bus_grant, .stack_push,
  .push_ccr, .stack_addr, .vec_fetch, .branch);

// *** testbench/test_cpu_processing_state_control.sv ***
`timescale 1ns/1ps
`include "psc_defines.vh"
module test_cpu_processing_state_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
  logic [7:0] paddr = 8'h00, irq_vec = 8'h00, vec_num;
  logic [31:0] pwdata = 32'h0, prdata, r, sp;
  logic reset_in_n = 1, hw_standby_in_n = 1, nmi_req = 0, irq_req = 0, wdt_overflow = 0, go = 0;
  logic irq_pri_req = 0;
  logic insn_done = 0, insn_ccr_op = 0, insn_sleep = 0, insn_trap = 0;
  logic bus_req, cpu_halt, clock_halt, module_reset, bus_grant, stack_push, push_ccr, vec_fetch, branch;
  logic [1:0] trap_num = 2'h0, pd_mode, tn;
  logic [2:0] cpu_state;
  logic [3:0] hold_len = 4'h0;
  logic [23:0] stack_addr;
  int n_mismatch = 0, compares = 0, seed;
  initial forever #20 pclk = ~pclk;
  psc_bus_peer u_peer (.pclk, .presetn, .go, .hold_len, .bus_grant, .bus_req);
  psc_top #(.HW_STANDBY_IN_N_WAIT(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_in_n, .hw_standby_in_n, .bus_req, .nmi_req, .irq_req, .irq_pri_req, .irq_vec,
    .wdt_overflow, .insn_done, .insn_ccr_op, .insn_sleep, .insn_trap, .trap_num, .cpu_state, .pd_mode,
    .cpu_halt, .clock_halt, .module_reset, .bus_grant, .stack_push, .push_ccr, .stack_addr, .vec_fetch,
    .vec_num, .branch);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    r = prdata;
    perr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (cpu_state !== s && n < 300) begin @(posedge pclk); n++; end
    chk({29'h0, cpu_state}, {29'h0, s});
  endtask
  task wait_vec(input logic [7:0] v);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (vec_fetch !== 1'b1 && n < 300);
    chk({24'h0, vec_num}, {24'h0, v});
  endtask
  task insn(input logic c, input logic s, input logic t);
    @(posedge pclk);
    insn_done <= 1; insn_ccr_op <= c; insn_sleep <= s; insn_trap <= t;
    @(posedge pclk);
    insn_done <= 0; insn_ccr_op <= 0; insn_sleep <= 0; insn_trap <= 0;
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = $urandom(94);
    tick(4);
    chk({29'h0, cpu_state}, 32'h3);
    presetn <= 1;
    wait_vec(`PSC_VEC_RESET);
    wait_st(3'h0);
    apb(0, `PSC_OFF_CCR, 0); chk(r, {24'h0, `PSC_CCR_RST});
    apb(0, `PSC_OFF_SYSCTRL, 0); chk(r, {24'h0, `PSC_SYSCTRL_RST});
    apb(0, 8'h10, 0); chk({31'h0, perr}, 32'h1);
    // unmasked irq pending across a ccr op right after reset: must stay ignored
    apb(1, `PSC_OFF_CCR, 0);
    irq_req <= 1; tick(6);
    insn(1, 0, 0); tick(2);
    chk({29'h0, cpu_state}, 32'h0);
    for (int ue = 1; ue >= 0; ue--) begin
      apb(1, `PSC_OFF_SYSCTRL, ue ? 32'h08 : 32'h00);
      apb(1, `PSC_OFF_CCR, 0);
      apb(0, `PSC_OFF_SP, 0); sp = r;
      irq_vec <= 8'h10 + 8'($urandom_range(200)); irq_req <= 1; tick(6);
      insn(0, 0, 0);
      wait_vec(irq_vec);
      irq_req <= 0;
      wait_st(3'h0);
      apb(0, `PSC_OFF_CCR, 0); chk(r, ue ? 32'h80 : 32'hC0);
      apb(0, `PSC_OFF_SP, 0); chk(r, (sp - 32'h8) & 32'h00FFFFFF);
    end
    // mask is set now, so a plain trap runs alone
    tn = 2'($urandom_range(3)); trap_num <= tn;
    insn(0, 0, 1);
    wait_vec(`PSC_VEC_TRAP_BASE + {6'h0, tn});
    wait_st(3'h0);
    apb(1, `PSC_OFF_CCR, 0);
    irq_req <= 1; tick(6);
    insn(0, 0, 1);
    wait_vec(irq_vec);
    irq_req <= 0;
    wait_st(3'h0);
    // user enable is 0: with the mask set, only the priority request passes while ui is clear
    apb(1, `PSC_OFF_CCR, 32'h80);
    irq_pri_req <= 1; tick(6);
    insn(0, 0, 0);
    wait_vec(irq_vec);
    wait_st(3'h0);
    insn(0, 0, 0); tick(2);
    chk({29'h0, cpu_state}, 32'h0);
    irq_pri_req <= 0;
    apb(1, `PSC_OFF_CCR, 0);
    irq_req <= 1; hold_len <= 4'($urandom_range(2, 12)); go <= 1; tick(1); go <= 0;
    wait_st(3'h4);
    tick(2); chk({31'h0, bus_grant}, 32'h1);
    // a boundary seen while released must not start the pending interrupt
    insn(0, 0, 0); tick(2);
    chk({29'h0, cpu_state}, 32'h4);
    wait_st(3'h0); tick(2);
    chk({29'h0, cpu_state}, 32'h0);
    insn(0, 0, 0);
    wait_vec(irq_vec);
    irq_req <= 0;
    wait_st(3'h0);
    for (int ss = 0; ss < 2; ss++) begin
      apb(1, `PSC_OFF_SYSCTRL, ss ? 32'h88 : 32'h08);
      insn(0, 1, 0);
      wait_st(3'h2);
      chk({30'h0, pd_mode}, ss);
      tick(2); chk({31'h0, clock_halt}, ss);
      nmi_req <= 1;
      wait_vec(`PSC_VEC_NMI);
      nmi_req <= 0;
      wait_st(3'h0);
    end
    hw_standby_in_n <= 0;
    wait_st(3'h2);
    chk({30'h0, pd_mode}, 32'h2);
    tick(2); chk({30'h0, clock_halt, module_reset}, 32'h3);
    hw_standby_in_n <= 1;
    wait_vec(`PSC_VEC_RESET);
    wait_st(3'h0);
    wdt_overflow <= 1;
    wait_st(3'h3);
    wdt_overflow <= 0;
    wait_vec(`PSC_VEC_RESET);
    wait_st(3'h0);
    reset_in_n <= 0;
    wait_st(3'h3);
    tick(3); chk({30'h0, cpu_halt, module_reset}, 32'h3);
    reset_in_n <= 1;
    wait_vec(`PSC_VEC_RESET);
    wait_st(3'h0);
    finish_test;
  end
  // whole run is a few hundred cycles; this limit of 20000 cycles is far beyond it
  initial begin
    #800000;
    n_mismatch++;
    finish_test;
  end
endmodule // test_cpu_processing_state_control
